/* File: inc/asc_map.vh */
/*
 * register offsets, field positions, reset values and timing counts for the slot control block.
 * assumes a 100 MHz clock and a 32-bit axi4-lite register bus.
 */
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
// ****************************************
// timing
// ****************************************
`define ASC_CLK_MHZ 100
`define ASC_US_CYCLES (`ASC_CLK_MHZ)
`define ASC_PREBIAS_US_RST 8'h08
// ****************************************
// address map
// ****************************************
`define ASC_GLOBAL_ADDR 8'h00
`define ASC_STATUS_ADDR 8'h04
`define ASC_SLOT_BASE 8'h40
`define ASC_SLOT_STRIDE 8'h08
`define ASC_SLOT_LED_OFS 8'h04
`define ASC_NUM_SLOTS 12
// ****************************************
// global register fields
// ****************************************
`define ASC_GL_DIFF_LSB 0
`define ASC_GL_IDLE_LSB 4
// ****************************************
// slot config register fields
// ****************************************
`define ASC_SC_ROUTE_LSB 0
`define ASC_SC_PREBIAS_LSB 16
`define ASC_SC_CH2_BIT 19
`define ASC_SC_WIDTH_LSB 20
`define ASC_SC_MODE_LSB 28
`define ASC_SC_RST 32'h00800000
// slot led register: four 7-bit codes from bit 0, four side selects from bit 28
`define ASC_SL_SIDE_LSB 28
`define ASC_SL_RST 32'h00000000
// ****************************************
// encodings and limits
// ****************************************
`define ASC_MODE_NORMAL 2'h0
`define ASC_MODE_DIGINT 2'h1
`define ASC_MODE_IMPULSE 2'h2
`define ASC_LIMIT_MA 10'h190
`define ASC_RESP_OKAY 2'h0
`define ASC_RESP_SLVERR 2'h2
`endif

/* File: core/asc_slot_ctrl.v */
/*
 * slot control for the sensor front end: input pair routing, idle and prebias states,
 * second channel gating, converter sharing, result ordering and emitter driver setup.
 * assumes a slot sequencer outside that pulses slot_start/slot_end and marks the pulse
 * region, a converter that answers adc_start with adc_done, and an axi4-lite master.
 */
// Function
// - twelve slots, each configured independently
// - both channels sample together, share one converter
// - each pair routed afresh every slot
// - pair differential choice global to all slots
// - slot route field enables and routes pair
// - disabled inputs take pair idle state
// - inputs active only in prebias or pulse
// - slot prebias field picks drive before sampling
// - prebias at slot start, width default 8us
// - second channel off by default, powered down
// - integration or impulse modes never use channel two
// - slot enable runs channel two conversions
// - channel two results follow channel one
// - four drivers, two sinks each, one lit
// - side select drives one sink, never both
// - 7-bit current code per driver per slot
// - codes to 15 step 1mA, above 2mA
// - code zero disables the driver
// - over 400mA, clip later drivers by priority
`timescale 1ns/1ps
`include "asc_map.vh"
module asc_slot_ctrl (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// slot sequencer
	input wire slot_start,
	input wire [3:0] slot_index,
	input wire slot_end,
	input wire pulse_region,
	input wire device_sleep,
	input wire sample_strobe,
	// converter
	input wire adc_done,
	output reg sample_hold,
	output reg adc_start,
	output reg adc_channel,
	// result writer
	output reg result_push,
	output reg result_channel,
	// input switch matrix
	output reg [3:0] inputs_differential_select,
	output reg [7:0] input_to_ch1,
	output reg [7:0] input_to_ch2,
	output reg [7:0] input_active,
	output reg [11:0] input_idle_state,
	output reg prebias_active,
	output reg [2:0] slot_input_prebias_select,
	// second channel
	output reg second_channel_power,
	// emitter drivers, sink 2k is side a and 2k+1 side b of driver k
	output reg [7:0] emitter_sink_on,
	output reg [27:0] emitter_current_code
);

// ****************************************
// helpers
// ****************************************
// approximate current in mA for a code; step 1 below 16, step 2 above
function [9:0] code_ma;
	input [6:0] code;
	begin
		if (code == 7'h00)
			code_ma = 10'h000;
		else if (code < 7'h10)
			code_ma = {3'h0, code} + 10'h001;
		else
			code_ma = 10'h010 + {2'h0, code - 7'h0f, 1'b0};
	end
endfunction

// largest code whose current fits in the remaining budget
function [6:0] code_fit;
	input [6:0] code;
	input [9:0] budget;
	reg [9:0] half;
	begin
		half = (budget - 10'h010) >> 1;
		if (code_ma(code) <= budget)
			code_fit = code;
		else if (budget < 10'h002)
			code_fit = 7'h00;
		else if (budget <= 10'h010)
			code_fit = budget[6:0] - 7'h01;
		else
			code_fit = 7'h0f + half[6:0];
	end
endfunction

// route code per pair: {in_b_ch2, in_b_ch1, in_a_ch2, in_a_ch1}
function [3:0] route_dec;
	input [3:0] code;
	input diff;
	begin
		case (code[2:0])
			3'h1: route_dec = 4'b0001;
			3'h2: route_dec = 4'b0010;
			3'h3: route_dec = 4'b1001;
			3'h4: route_dec = 4'b0110;
			3'h5: route_dec = 4'b0100;
			3'h6: route_dec = 4'b1000;
			default: route_dec = 4'b0000;
		endcase
		// a differential pair lands both legs on channel 1 if either leg routes there, otherwise both on channel 2
		if (diff && code[2:0] != 3'h0)
			route_dec = (route_dec[0] | route_dec[2]) ? 4'b0101 : 4'b1010;
	end
endfunction

// ****************************************
// register storage
// ****************************************
reg [15:0] global_cfg;
reg [31:0] slot_cfg [0:11];
reg [31:0] slot_led [0:11];
reg [3:0] clip_seen;
reg slot_busy;
reg [3:0] cur_slot;
integer i;

// ****************************************
// axi4-lite slave
// ****************************************
reg aw_held;
reg w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire [7:0] wr_rel = aw_addr - `ASC_SLOT_BASE;
wire [7:0] rd_rel = s_axi_araddr - `ASC_SLOT_BASE;
wire wr_slot_hit = aw_addr >= `ASC_SLOT_BASE && wr_rel[7:3] < `ASC_NUM_SLOTS && aw_addr[1:0] == 2'h0;
wire rd_slot_hit = s_axi_araddr >= `ASC_SLOT_BASE && rd_rel[7:3] < `ASC_NUM_SLOTS && s_axi_araddr[1:0] == 2'h0;
wire do_write = aw_held && w_held && !s_axi_bvalid;

function [31:0] merge;
	input [31:0] old;
	input [31:0] data;
	input [3:0] strb;
	integer b;
	begin
		merge = old;
		for (b = 0; b < 4; b = b + 1)
			if (strb[b])
				merge[b*8 +: 8] = data[b*8 +: 8];
	end
endfunction

// the global register is only 16 bits wide, so the merged word is cut on purpose
wire [31:0] global_merged = merge({16'h0000, global_cfg}, w_data, w_strb);

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `ASC_RESP_OKAY;
		global_cfg <= 16'h0000;
		for (i = 0; i < `ASC_NUM_SLOTS; i = i + 1) begin
			slot_cfg[i] <= `ASC_SC_RST;
			slot_led[i] <= `ASC_SL_RST;
		end
	end else begin
		s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
		s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `ASC_RESP_OKAY;
			if (aw_addr == `ASC_GLOBAL_ADDR)
				global_cfg <= global_merged[15:0];
			else if (aw_addr == `ASC_STATUS_ADDR)
				s_axi_bresp <= `ASC_RESP_OKAY;
			else if (wr_slot_hit && wr_rel[2])
				slot_led[wr_rel[6:3]] <= merge(slot_led[wr_rel[6:3]], w_data, w_strb);
			else if (wr_slot_hit)
				slot_cfg[wr_rel[6:3]] <= merge(slot_cfg[wr_rel[6:3]], w_data, w_strb);
			else
				s_axi_bresp <= `ASC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `ASC_RESP_OKAY;
	end else begin
		s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `ASC_RESP_OKAY;
			if (s_axi_araddr == `ASC_GLOBAL_ADDR)
				s_axi_rdata <= {16'h0000, global_cfg};
			else if (s_axi_araddr == `ASC_STATUS_ADDR)
				s_axi_rdata <= {22'h000000, clip_seen, prebias_active, slot_busy, cur_slot};
			else if (rd_slot_hit && rd_rel[2])
				s_axi_rdata <= slot_led[rd_rel[6:3]];
			else if (rd_slot_hit)
				s_axi_rdata <= slot_cfg[rd_rel[6:3]];
			else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `ASC_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

// ****************************************
// slot capture and emitter budget
// ****************************************
// settings are copied at slot start so software may rewrite a slot while it runs
wire [3:0] sel_slot = (slot_index < `ASC_NUM_SLOTS) ? slot_index : 4'h0;
wire [31:0] new_cfg = slot_cfg[sel_slot];
wire [31:0] new_led = slot_led[sel_slot];
wire [1:0] new_mode = new_cfg[`ASC_SC_MODE_LSB +: 2];
wire new_ch2 = new_cfg[`ASC_SC_CH2_BIT] && new_mode == `ASC_MODE_NORMAL;
reg [27:0] fit_code;
reg [3:0] fit_clip;
reg [9:0] budget;
reg [6:0] one_code;
integer d;

always @* begin
	budget = `ASC_LIMIT_MA;
	fit_code = 28'h0000000;
	fit_clip = 4'h0;
	one_code = 7'h00;
	// driver one is served first, later drivers take what remains
	for (d = 0; d < 4; d = d + 1) begin
		one_code = code_fit(new_led[d*7 +: 7], budget);
		fit_code[d*7 +: 7] = one_code;
		fit_clip[d] = one_code != new_led[d*7 +: 7];
		budget = budget - code_ma(one_code);
	end
end

reg [31:0] cur_cfg;
reg ch2_on;
reg [7:0] route1;
reg [7:0] route2;
reg [6:0] us_div;
reg [7:0] prebias_left;
integer p;

always @(posedge aclk) begin
	if (!aresetn) begin
		slot_busy <= 1'b0;
		cur_slot <= 4'h0;
		cur_cfg <= `ASC_SC_RST;
		ch2_on <= 1'b0;
		route1 <= 8'h00;
		route2 <= 8'h00;
		clip_seen <= 4'h0;
		emitter_sink_on <= 8'h00;
		emitter_current_code <= 28'h0000000;
		second_channel_power <= 1'b0;
		prebias_left <= 8'h00;
		us_div <= 7'h00;
	end else if (slot_start && slot_index < `ASC_NUM_SLOTS) begin
		slot_busy <= 1'b1;
		cur_slot <= slot_index;
		cur_cfg <= new_cfg;
		ch2_on <= new_ch2;
		second_channel_power <= new_ch2;
		clip_seen <= fit_clip;
		emitter_current_code <= fit_code;
		for (p = 0; p < 4; p = p + 1) begin
			{route2[2*p+1], route1[2*p+1], route2[2*p], route1[2*p]} <=
				route_dec(new_cfg[p*4 +: 4], global_cfg[p]) & (new_ch2 ? 4'hf : 4'h5);
			// one sink per pair, chosen by side select, dark for code zero
			emitter_sink_on[2*p] <= !new_led[`ASC_SL_SIDE_LSB + p] && fit_code[p*7 +: 7] != 7'h00;
			emitter_sink_on[2*p+1] <= new_led[`ASC_SL_SIDE_LSB + p] && fit_code[p*7 +: 7] != 7'h00;
		end
		prebias_left <= new_cfg[`ASC_SC_WIDTH_LSB +: 8];
		us_div <= 7'h00;
	end else if (slot_end) begin
		slot_busy <= 1'b0;
		ch2_on <= 1'b0;
		second_channel_power <= 1'b0;
		route1 <= 8'h00;
		route2 <= 8'h00;
		emitter_sink_on <= 8'h00;
		emitter_current_code <= 28'h0000000;
		prebias_left <= 8'h00;
	end else if (prebias_left != 8'h00) begin
		// microsecond tick from a divider on the system clock
		if (us_div == `ASC_US_CYCLES - 1) begin
			us_div <= 7'h00;
			prebias_left <= prebias_left - 8'h01;
		end else begin
			us_div <= us_div + 7'h01;
		end
	end
end

// ****************************************
// input states
// ****************************************
wire [7:0] enabled = route1 | route2;
wire region = slot_busy && !device_sleep && (prebias_left != 8'h00 || pulse_region);

always @(posedge aclk) begin
	if (!aresetn) begin
		inputs_differential_select <= 4'h0;
		input_idle_state <= 12'h000;
		input_active <= 8'h00;
		input_to_ch1 <= 8'h00;
		input_to_ch2 <= 8'h00;
		prebias_active <= 1'b0;
		slot_input_prebias_select <= 3'h0;
	end else begin
		inputs_differential_select <= global_cfg[`ASC_GL_DIFF_LSB +: 4];
		input_idle_state <= global_cfg[`ASC_GL_IDLE_LSB +: 12];
		// outside the active regions every input falls back to its pair's idle state
		input_active <= region ? enabled : 8'h00;
		input_to_ch1 <= region ? route1 : 8'h00;
		input_to_ch2 <= region ? route2 : 8'h00;
		prebias_active <= slot_busy && !device_sleep && prebias_left != 8'h00;
		slot_input_prebias_select <= cur_cfg[`ASC_SC_PREBIAS_LSB +: 3];
	end
end

// ****************************************
// converter sharing and result order
// ****************************************
localparam ST_IDLE = 3'h0;
localparam ST_CONV1 = 3'h1;
localparam ST_CONV2 = 3'h2;
localparam ST_WAIT_END = 3'h3;
localparam ST_PUSH2 = 3'h4;
reg [2:0] state;
reg have_data;

always @(posedge aclk) begin
	if (!aresetn) begin
		state <= ST_IDLE;
		have_data <= 1'b0;
		sample_hold <= 1'b0;
		adc_start <= 1'b0;
		adc_channel <= 1'b0;
		result_push <= 1'b0;
		result_channel <= 1'b0;
	end else begin
		sample_hold <= 1'b0;
		adc_start <= 1'b0;
		result_push <= 1'b0;
		if (slot_start)
			have_data <= 1'b0;
		case (state)
			ST_IDLE: begin
				if (slot_busy && sample_strobe) begin
					// both channels freeze together, then convert in turn
					sample_hold <= 1'b1;
					adc_start <= 1'b1;
					adc_channel <= 1'b0;
					state <= ST_CONV1;
				end else if (slot_end && have_data) begin
					result_push <= 1'b1;
					result_channel <= 1'b0;
					state <= ch2_on ? ST_PUSH2 : ST_IDLE;
				end
			end
			ST_CONV1: begin
				if (adc_done) begin
					have_data <= 1'b1;
					if (ch2_on) begin
						adc_start <= 1'b1;
						adc_channel <= 1'b1;
						state <= ST_CONV2;
					end else begin
						state <= ST_WAIT_END;
					end
				end
			end
			ST_CONV2: begin
				if (adc_done)
					state <= ST_WAIT_END;
			end
			ST_WAIT_END: begin
				state <= ST_IDLE;
			end
			ST_PUSH2: begin
				result_push <= 1'b1;
				result_channel <= 1'b1;
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
		endcase
	end
end

endmodule

/* File: test/asc_slot_checker.sv */
/*
 * port-level properties of the slot control block.
 * assumes it is bound to asc_slot_ctrl, one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module asc_slot_checker (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// sequencer and converter
	input wire device_sleep,
	input wire slot_start,
	input wire slot_end,
	input wire sample_hold,
	input wire adc_start,
	input wire adc_channel,
	input wire result_push,
	input wire result_channel,
	// analog side
	input wire [7:0] input_active,
	input wire second_channel_power,
	input wire [7:0] emitter_sink_on,
	input wire [27:0] emitter_current_code
);
	// ****************************
	// current model and properties
	// ****************************
	function automatic [9:0] to_ma(input [6:0] c);
		to_ma = (c == 7'h00) ? 10'd0 : (c < 7'h10) ? {3'h0, c} + 10'd1 : 10'd16 + 10'd2 * ({3'h0, c} - 10'd15);
	endfunction
	wire [9:0] total_ma = to_ma(emitter_current_code[6:0]) + to_ma(emitter_current_code[13:7])
		+ to_ma(emitter_current_code[20:14]) + to_ma(emitter_current_code[27:21]);
	wire [3:0] drv_on = {|emitter_sink_on[7:6], |emitter_sink_on[5:4], |emitter_sink_on[3:2], |emitter_sink_on[1:0]};
	wire [3:0] drv_zero = {emitter_current_code[27:21] == 7'h00, emitter_current_code[20:14] == 7'h00,
		emitter_current_code[13:7] == 7'h00, emitter_current_code[6:0] == 7'h00};
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	one_side_a: assert property (~|(emitter_sink_on & {emitter_sink_on[6:0], 1'b0} & 8'haa))
		else $error("both sinks of one driver on");
	zero_off_a: assert property (~|(drv_on & drv_zero))
		else $error("sink on with zero current code");
	total_limit_a: assert property (total_ma <= 10'd400)
		else $error("combined current above limit");
	ch2_after_a: assert property (result_push && result_channel |-> $past(result_push) && !$past(result_channel))
		else $error("second channel result not after first");
	hold_start_a: assert property (sample_hold |-> adc_start && !adc_channel)
		else $error("sample without first channel conversion");
	ch2_power_a: assert property (adc_start && adc_channel |-> second_channel_power)
		else $error("second channel converted while powered down");
	sleep_idle_a: assert property (device_sleep [*3] |-> input_active == 8'h00)
		else $error("input active during sleep");
	slot_hold_a: assert property (!$stable(emitter_current_code) |-> $past(slot_start) || $past(slot_end))
		else $error("drive code changed inside slot");
	cover property (result_push && result_channel);
	cover property (total_ma == 10'd400);
	cover property (sample_hold);
endmodule
bind asc_slot_ctrl asc_slot_checker u_asc_slot_checker (.aclk(aclk), .aresetn(aresetn),
	.device_sleep(device_sleep), .slot_start(slot_start), .slot_end(slot_end), .sample_hold(sample_hold),
	.adc_start(adc_start), .adc_channel(adc_channel), .result_push(result_push),
	.result_channel(result_channel), .input_active(input_active), .second_channel_power(second_channel_power),
	.emitter_sink_on(emitter_sink_on), .emitter_current_code(emitter_current_code));

/* File: test/asc_adc_model.sv */
/*
 * shared converter model: one conversion at a time, done after a settable latency.
 * assumes adc_start is a one-cycle pulse and lat is at least one.
 */
`timescale 1ns/1ps
module asc_adc_model (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// converter handshake
	input wire [3:0] lat,
	input wire adc_start,
	output logic adc_done
);
	logic [3:0] cnt;
	// one counter for both channels, so they time-share the converter
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 4'h0;
			adc_done <= 1'b0;
		end else begin
			adc_done <= (cnt == 4'h1);
			if (adc_start)
				cnt <= lat;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule

/* File: test/tb.sv */
/*
 * self-checking bench for the slot control block: axi4-lite tasks, slot runs, converter model.
 * assumes a 100 MHz clock and that the checker is bound in its own file.
 */
`timescale 1ns/1ps
`include "asc_map.vh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf, slot_index = 4'h0, adc_lat = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic slot_start = 1'b0, slot_end = 1'b0, pulse_region = 1'b0, device_sleep = 1'b0, sample_strobe = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire adc_done, sample_hold, adc_start, adc_channel, result_push, result_channel, prebias_active;
	wire second_channel_power;
	wire [3:0] inputs_differential_select;
	wire [7:0] input_to_ch1, input_to_ch2, input_active, emitter_sink_on;
	wire [11:0] input_idle_state;
	wire [2:0] slot_input_prebias_select;
	wire [27:0] emitter_current_code;
	int fails = 0, cmp_count = 0, cyc = 0, push_n = 0, ch2_n = 0;
	logic [3:0] res_log = 4'h0;
	logic [1:0] resp;
	logic [31:0] rd_data;
	initial forever #5 aclk = ~aclk;
	asc_slot_ctrl u_asc_slot_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .slot_start(slot_start), .slot_index(slot_index), .slot_end(slot_end),
		.pulse_region(pulse_region), .device_sleep(device_sleep), .sample_strobe(sample_strobe),
		.adc_done(adc_done), .sample_hold(sample_hold), .adc_start(adc_start), .adc_channel(adc_channel),
		.result_push(result_push), .result_channel(result_channel),
		.inputs_differential_select(inputs_differential_select), .input_to_ch1(input_to_ch1),
		.input_to_ch2(input_to_ch2), .input_active(input_active), .input_idle_state(input_idle_state),
		.prebias_active(prebias_active), .slot_input_prebias_select(slot_input_prebias_select),
		.second_channel_power(second_channel_power), .emitter_sink_on(emitter_sink_on),
		.emitter_current_code(emitter_current_code));
	asc_adc_model u_asc_adc_model (.aclk(aclk), .aresetn(aresetn), .lat(adc_lat), .adc_start(adc_start),
		.adc_done(adc_done));
	// ****************************
	// tasks
	// ****************************
	task complete_run;
		$display("Mismatches %0d, comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic run_slot(input logic [3:0] idx);
		@(posedge aclk);
		slot_index <= idx;
		slot_start <= 1'b1;
		@(posedge aclk);
		slot_start <= 1'b0;
		repeat (3) @(posedge aclk);
		#1;
	endtask
	// one sample, then close the slot so results are pushed
	task automatic finish_slot;
		@(posedge aclk);
		pulse_region <= 1'b1;
		sample_strobe <= 1'b1;
		@(posedge aclk);
		sample_strobe <= 1'b0;
		repeat (30) @(posedge aclk);
		pulse_region <= 1'b0;
		slot_end <= 1'b1;
		@(posedge aclk);
		slot_end <= 1'b0;
		repeat (5) @(posedge aclk);
		#1;
	endtask
	// ****************************
	// monitors and sequence
	// ****************************
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (result_push) begin
			push_n <= push_n + 1;
			res_log <= {res_log[2:0], result_channel};
		end
		if (adc_start && adc_channel)
			ch2_n <= ch2_n + 1;
		if (cyc == 5000) begin
			fails++;
			complete_run;
		end
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(8'h40);
		`CHK(rd_data, `ASC_SC_RST)
		axi_rd(8'h44);
		`CHK(rd_data, 32'h00000000)
		axi_rd(8'hfc);
		`CHK(resp, `ASC_RESP_SLVERR)
		axi_wr(8'h00, 32'h00001232);
		`CHK(resp, `ASC_RESP_OKAY)
		axi_wr(8'h58, 32'h001b0013);
		axi_wr(8'h5c, 32'h10000010);
		axi_rd(8'h5c);
		`CHK(rd_data, 32'h10000010)
		run_slot(4'h3);
		`CHK(inputs_differential_select, 4'h2)
		`CHK(input_to_ch1, 8'h0d)
		`CHK(input_to_ch2, 8'h02)
		`CHK(input_active, 8'h0f)
		`CHK(slot_input_prebias_select, 3'h3)
		`CHK(prebias_active, 1'b1)
		`CHK(emitter_sink_on, 8'h02)
		`CHK(emitter_current_code, 28'h0000010)
		`CHK(second_channel_power, 1'b1)
		repeat (110) @(posedge aclk);
		#1;
		`CHK(prebias_active, 1'b0)
		`CHK(input_active, 8'h00)
		finish_slot;
		`CHK(push_n, 2)
		`CHK(res_log[1:0], 2'b01)
		`CHK(ch2_n, 1)
		`CHK(emitter_sink_on, 8'h00)
		// slower converter; 150+150+100 mA fills the budget, driver four gets nothing
		@(posedge aclk) adc_lat <= 4'h9;
		axi_wr(8'h6c, 32'h00b4a952);
		for (int m = 1; m < 3; m++) begin
			axi_wr(8'h68, 32'h00080001 | (32'(m) << 28));
			run_slot(4'h5);
			`CHK(second_channel_power, 1'b0)
			`CHK(emitter_current_code, 28'h00e6952)
			`CHK(emitter_sink_on[5:0], 6'h15)
			finish_slot;
		end
		`CHK(ch2_n, 1)
		`CHK(push_n, 4)
		run_slot(4'hc);
		`CHK(emitter_sink_on, 8'h00)
		// an out-of-range slot must leave slot 5 and its clipped drivers in the status word
		axi_rd(8'h04);
		`CHK(rd_data, 32'h00000305)
		@(posedge aclk) device_sleep <= 1'b1;
		run_slot(4'h3);
		`CHK(input_active, 8'h00)
		`CHK(input_idle_state, 12'h123)
		finish_slot;
		complete_run;
	end
endmodule
